// ### hdl/pfsr_defs.svh
// Constants for the fault status reporting block
// Behaviour
// - A latched fault is released by a control pin toggle, an on/off command, or a bias power cycle.
// - Every fault or warning pulls the alert output low and sets its status bits.
// - A clear-faults command empties the status registers except word bits 11 and 6 while their conditions hold, and releases the alert.
// - The alert output is released once the faults have been reset by any reset method.
// - The summary byte is the low eight bits of the summary word, from the same storage.
// - Word bit 15 flags output voltage events, bit 13 input voltage events, bit 12 manufacturer faults.
// - Word bit 11 is set while power-good is enabled and negated.
// - Word bits 14, 10, 9, 8, 4 and output voltage status bits 1 and 0 always read zero.
// - Word bit 7 is set when a command arrives while the device is still busy.
// - Word bit 6 is set whenever power is not permitted and clears only while power is permitted.
// - Word bit 5 flags output overvoltage fault and bit 3 input undervoltage fault.
// - Word bit 2 flags temperature events and bit 1 communication, memory or logic faults.
// - Word bit 0 flags manufacturer faults, other input events, and output voltage events in a cycle without an overvoltage fault.
// - Output voltage status holds overvoltage fault 7, overvoltage warning 6, undervoltage warning 5, undervoltage fault 4, turn-on timeout 2.
// - Output voltage bit 3 flags an over-maximum command and after a clear is muted until off-then-on or a valid lower setting.
`ifndef PFSR_DEFS_SVH
`define PFSR_DEFS_SVH
// ----------------------------------------
// Register selects
// ----------------------------------------
`define PFSR_SEL_BYTE 2'h0
`define PFSR_SEL_WORD 2'h1
`define PFSR_SEL_VOUT 2'h2
// ----------------------------------------
// Summary word bit positions
// ----------------------------------------
`define PFSR_W_VOUT 15
`define PFSR_W_INPUT 13
`define PFSR_W_MFR 12
`define PFSR_W_PNG 11
`define PFSR_W_BUSY 7
`define PFSR_W_OFF 6
`define PFSR_W_VOUT_OV 5
`define PFSR_W_VIN_UV 3
`define PFSR_W_TEMP 2
`define PFSR_W_CML 1
`define PFSR_W_HIGH 0
// ----------------------------------------
// Output voltage status bit positions
// ----------------------------------------
`define PFSR_V_OV_FLT 7
`define PFSR_V_OV_WRN 6
`define PFSR_V_UV_WRN 5
`define PFSR_V_UV_FLT 4
`define PFSR_V_MAX_FLT 3
`define PFSR_V_TON_FLT 2
// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define PFSR_WORD_RST 16'h0040
`define PFSR_VOUT_RST 8'h00
`define PFSR_WORD_MASK 16'hB8EF
`define PFSR_VOUT_MASK 8'hFC
`define PFSR_NUM_SLOTS 3
`endif

// ### hdl/pfsr_pkg.sv
// Types for the fault status reporting block
package pfsr_pkg;
  typedef enum logic [1:0] {
    PFSR_IDLE,
    PFSR_BUSY
  } pfsr_cmd_state_t;
endpackage : pfsr_pkg

// ### hdl/pfsr_status_mem.sv
// Small register memory holding the status words with registered read
`timescale 1ns/1ps
`include "pfsr_defs.svh"
module pfsr_status_mem
  import pfsr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [15:0] wr_word_i,
  input wire logic [7:0] wr_vout_i,
  // Read port
  input wire logic [1:0] rd_sel_i,
  output logic [15:0] rd_data_o
);
  typedef struct packed {
    logic [15:0] word;
    logic [7:0] vout;
    logic [15:0] rd;
  } pfsr_mem_state_t;

  pfsr_mem_state_t st_ff;
  pfsr_mem_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (wr_en_i) begin
      nxt_st.word = wr_word_i;
      nxt_st.vout = wr_vout_i;
    end
    unique case (rd_sel_i)
      `PFSR_SEL_BYTE: nxt_st.rd = {8'h00, st_ff.word[7:0]};
      `PFSR_SEL_WORD: nxt_st.rd = st_ff.word;
      `PFSR_SEL_VOUT: nxt_st.rd = {8'h00, st_ff.vout};
      default: nxt_st.rd = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_ff <= '{word: `PFSR_WORD_RST, vout: `PFSR_VOUT_RST, rd: 16'h0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data_o = st_ff.rd;

  byte_copy_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_sel_i == `PFSR_SEL_BYTE |=> rd_data_o == {8'h00, $past(st_ff.word[7:0])})
    else $error("status byte is not the word low byte");
endmodule : pfsr_status_mem

// ### hdl/pfsr_fault_status.sv
// Fault and warning status latching, alert output and status readback
`timescale 1ns/1ps
`include "pfsr_defs.svh"
module pfsr_fault_status
  import pfsr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Output voltage events, one-cycle or level
  input wire logic vout_ov_fault_i,
  input wire logic vout_ov_warn_i,
  input wire logic vout_uv_warn_i,
  input wire logic vout_uv_fault_i,
  input wire logic vout_max_req_i,
  input wire logic vout_valid_low_i,
  input wire logic ton_max_fault_i,
  // Other event summaries
  input wire logic input_event_i,
  input wire logic vin_uv_fault_i,
  input wire logic mfr_fault_i,
  input wire logic temp_event_i,
  input wire logic cml_fault_i,
  // Channel state
  input wire logic power_good_en_i,
  input wire logic power_good_out_i,
  input wire logic power_permitted_i,
  input wire logic channel_on_i,
  // Command interface
  input wire logic cmd_valid_i,
  input wire logic cmd_done_i,
  input wire logic clear_faults_i,
  input wire logic control_toggle_i,
  input wire logic on_off_cmd_i,
  input wire logic bias_supply_sense_pin,
  // Register read
  input wire logic [1:0] rd_sel_i,
  output logic [15:0] rd_data_o,
  // Alert pin, open drain
  output logic fault_alert_out_n_o,
  output logic fault_alert_oe_n_o
);
  typedef struct packed {
    logic [15:0] word;
    logic [7:0] vout;
    logic max_mute;
    logic chan_on;
    logic bias;
    logic bias_seen_low;
    pfsr_cmd_state_t cmd;
    logic alert;
  } pfsr_state_t;

  pfsr_state_t st_ff;
  pfsr_state_t nxt_st;
  logic reset_evt;
  logic busy_evt;
  logic max_evt;
  logic [7:0] vout_set;
  logic [15:0] word_set;
  logic [15:0] word_lvl;

  function automatic logic any_bit(input logic [15:0] v);
    any_bit = |v;
  endfunction : any_bit

  always_comb begin
    // Latched reset by pin toggle, on/off command or bias cycle
    reset_evt = control_toggle_i || on_off_cmd_i
             || (bias_supply_sense_pin && st_ff.bias_seen_low);
    busy_evt = cmd_valid_i && (st_ff.cmd == PFSR_BUSY);
    max_evt = vout_max_req_i && !st_ff.max_mute;
    vout_set = 8'h00;
    vout_set[`PFSR_V_OV_FLT] = vout_ov_fault_i;
    vout_set[`PFSR_V_OV_WRN] = vout_ov_warn_i;
    vout_set[`PFSR_V_UV_WRN] = vout_uv_warn_i;
    vout_set[`PFSR_V_UV_FLT] = vout_uv_fault_i;
    vout_set[`PFSR_V_TON_FLT] = ton_max_fault_i;
    vout_set[`PFSR_V_MAX_FLT] = max_evt;
    word_set = 16'h0000;
    word_set[`PFSR_W_VOUT] = any_bit({8'h00, vout_set});
    word_set[`PFSR_W_INPUT] = input_event_i || vin_uv_fault_i;
    word_set[`PFSR_W_MFR] = mfr_fault_i;
    word_set[`PFSR_W_BUSY] = busy_evt;
    word_set[`PFSR_W_VOUT_OV] = vout_ov_fault_i;
    word_set[`PFSR_W_VIN_UV] = vin_uv_fault_i;
    word_set[`PFSR_W_TEMP] = temp_event_i;
    word_set[`PFSR_W_CML] = cml_fault_i;
    // Events not shown in the low byte
    word_set[`PFSR_W_HIGH] = (any_bit({8'h00, vout_set}) && !vout_ov_fault_i)
                          || input_event_i || mfr_fault_i;
    word_lvl = 16'h0000;
    word_lvl[`PFSR_W_PNG] = power_good_en_i && !power_good_out_i;
    word_lvl[`PFSR_W_OFF] = !power_permitted_i;

    nxt_st = st_ff;
    nxt_st.bias = bias_supply_sense_pin;
    nxt_st.chan_on = channel_on_i;
    if (!bias_supply_sense_pin) begin
      nxt_st.bias_seen_low = 1'b1;
    end else begin
      nxt_st.bias_seen_low = 1'b0;
    end
    unique case (st_ff.cmd)
      PFSR_IDLE: if (cmd_valid_i) nxt_st.cmd = PFSR_BUSY;
      PFSR_BUSY: if (cmd_done_i) nxt_st.cmd = PFSR_IDLE;
    endcase
    // Mute max fault after clear until off-then-on or valid lower value
    if (clear_faults_i) begin
      nxt_st.max_mute = 1'b1;
    end
    if ((channel_on_i && !st_ff.chan_on) || vout_valid_low_i) begin
      nxt_st.max_mute = 1'b0;
    end
    // Sticky bits; new events win over a clear in the same cycle
    if (clear_faults_i || reset_evt) begin
      nxt_st.word = 16'h0000;
      nxt_st.vout = 8'h00;
    end
    nxt_st.word = (nxt_st.word | word_set | word_lvl) & `PFSR_WORD_MASK;
    nxt_st.vout = (nxt_st.vout | vout_set) & `PFSR_VOUT_MASK;
    nxt_st.alert = any_bit(word_set) || (st_ff.alert && !(clear_faults_i || reset_evt));
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_ff <= '{word: `PFSR_WORD_RST, vout: `PFSR_VOUT_RST, max_mute: 1'b0,
                 chan_on: 1'b0, bias: 1'b0, bias_seen_low: 1'b0,
                 cmd: PFSR_IDLE, alert: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Alert pin is open drain: enable low pulls the wire low
  logic alert_out_n_ff;
  always_ff @(posedge clk_i) begin
    alert_out_n_ff <= 1'b0;
  end
  assign fault_alert_out_n_o = alert_out_n_ff;
  logic alert_oe_n_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      alert_oe_n_ff <= 1'b1;
    end else begin
      alert_oe_n_ff <= !nxt_st.alert;
    end
  end
  assign fault_alert_oe_n_o = alert_oe_n_ff;

  pfsr_status_mem u_mem (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(1'b1),
    .wr_word_i(st_ff.word),
    .wr_vout_i(st_ff.vout),
    .rd_sel_i(rd_sel_i),
    .rd_data_o(rd_data_o)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence clr_s;
    clear_faults_i && !any_bit(word_set);
  endsequence

  alert_on_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    vout_ov_fault_i |=> !fault_alert_oe_n_o && st_ff.word[`PFSR_W_VOUT_OV])
    else $error("fault did not pull alert low");
  clear_all_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    clr_s |=> fault_alert_oe_n_o && st_ff.vout == 8'h00)
    else $error("clear did not empty status");
  reset_rel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (control_toggle_i || on_off_cmd_i) && !any_bit(word_set) |=> fault_alert_oe_n_o)
    else $error("alert not released after reset");
  zero_bits_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_ff.word & ~`PFSR_WORD_MASK) == 16'h0000 && st_ff.vout[1:0] == 2'b00)
    else $error("unsupported bit set");
  busy_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cmd_valid_i && !cmd_done_i ##1 cmd_valid_i |=> st_ff.word[`PFSR_W_BUSY])
    else $error("busy bit not set");
  off_bit_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !power_permitted_i |=> st_ff.word[`PFSR_W_OFF])
    else $error("off bit missing");
  png_bit_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    power_good_en_i && !power_good_out_i |=> st_ff.word[`PFSR_W_PNG])
    else $error("power not good bit missing");
  max_mute_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    clr_s ##0 (!vout_valid_low_i && !(channel_on_i && !st_ff.chan_on))
      ##1 (vout_max_req_i && !vout_valid_low_i && !(channel_on_i && !st_ff.chan_on))
      |=> !st_ff.vout[`PFSR_V_MAX_FLT])
    else $error("max fault reported while muted");
  sticky_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_ff.vout[`PFSR_V_UV_FLT] && !clear_faults_i && !reset_evt
      |=> st_ff.vout[`PFSR_V_UV_FLT])
    else $error("status bit dropped without clear");
endmodule : pfsr_fault_status

// ### dv/pfsr_host_model.sv
// Host model that reads the status registers
`timescale 1ns/1ps
module pfsr_host_model (
  // Clock
  input wire logic clk_i,
  // Register read
  output logic [1:0] rd_sel_o,
  input wire logic [15:0] rd_data_i
);
  initial rd_sel_o = 2'h0;
  // Select at the falling edge, sample once the registered data has settled
  task automatic rd(input logic [1:0] s, output logic [15:0] d);
    @(negedge clk_i) rd_sel_o = s;
    repeat (2) @(posedge clk_i);
    #1 d = rd_data_i;
  endtask : rd
endmodule : pfsr_host_model

// ### dv/testbench.sv
// Self-checking bench for the fault status reporting block
`timescale 1ns/1ps
module testbench;
  logic clk_i, rst_b_i, cmd_v, cmd_d, clr, tog, onoff, bias, vlow;
  logic pg_en, pg_out, perm, chon, oe_n, al_n;
  logic [10:0] ev;
  logic [1:0] sel;
  logic [15:0] rd, w, we, m;
  logic [7:0] ve;
  logic [31:0] lfsr;
  int bad_count, compares;
  localparam logic [15:0] WEXP [11] = '{16'h8020, 16'h8001, 16'h8001, 16'h8001, 16'h8001,
    16'h8001, 16'h2001, 16'h2008, 16'h1001, 16'h0004, 16'h0002};
  localparam logic [7:0] VEXP [11] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  pfsr_fault_status DUT (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .vout_ov_fault_i(ev[0]), .vout_ov_warn_i(ev[1]),
    .vout_uv_warn_i(ev[2]), .vout_uv_fault_i(ev[3]), .vout_max_req_i(ev[4]),
    .vout_valid_low_i(vlow), .ton_max_fault_i(ev[5]), .input_event_i(ev[6]),
    .vin_uv_fault_i(ev[7]), .mfr_fault_i(ev[8]), .temp_event_i(ev[9]), .cml_fault_i(ev[10]),
    .power_good_en_i(pg_en), .power_good_out_i(pg_out), .power_permitted_i(perm),
    .channel_on_i(chon), .cmd_valid_i(cmd_v), .cmd_done_i(cmd_d), .clear_faults_i(clr),
    .control_toggle_i(tog), .on_off_cmd_i(onoff), .bias_supply_sense_pin(bias),
    .rd_sel_i(sel), .rd_data_o(rd), .fault_alert_out_n_o(al_n), .fault_alert_oe_n_o(oe_n));
  pfsr_host_model host (.clk_i(clk_i), .rd_sel_o(sel), .rd_data_i(rd));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [15:0] msk(input int i);
    return (i < 0) ? 16'h0000 : 16'hF7BF;
  endfunction : msk
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk16
  task automatic chk1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk1
  // One-cycle events and clear, then let the result reach the read port
  task automatic pulse(input logic [10:0] p, input logic c);
    @(negedge clk_i);
    ev = p;
    clr = c;
    @(negedge clk_i);
    ev = '0;
    clr = 1'b0;
    vlow = 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : pulse
  task automatic check(input logic [15:0] e, input logic [15:0] k, input logic [7:0] v,
                       input logic a);
    host.rd(2'h1, w);
    chk16(w & k, e & k);
    host.rd(2'h0, w);
    chk16(w & {8'h00, k[7:0]}, {8'h00, e[7:0] & k[7:0]});
    host.rd(2'h2, w);
    chk16(w & 16'h00FF, {8'h00, v});
    host.rd(2'h3, w);
    chk16(w, 16'h0000);
    chk1(oe_n, a);
    chk1(al_n, 1'b0);
  endtask : check
  task automatic end_sim;
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end
  initial begin
    rst_b_i = 1'b0;
    ev = '0;
    {cmd_v, cmd_d, clr, tog, onoff, vlow} = '0;
    {bias, pg_en, pg_out, perm, chon} = '1;
    lfsr = 32'hDB7E;
    bad_count = 0;
    compares = 0;
    repeat (12) @(negedge clk_i);
    rst_b_i = 1'b1;
    check(16'h0000, 16'hF7BF, 8'h00, 1'b1);
    for (int i = 0; i < 11; i++) begin
      @(negedge clk_i) vlow = (i == 4);
      pulse(11'(1 << i), 1'b0);
      check(WEXP[i], msk(i), VEXP[i], 1'b0);
      pulse('0, 1'b1);
      check(16'h0000, 16'hF7BF, 8'h00, 1'b1);
    end
    pulse(11'h010, 1'b0);
    check(16'h0000, 16'hF7BF, 8'h00, 1'b1);
    @(negedge clk_i) chon = 1'b0;
    @(negedge clk_i) chon = 1'b1;
    pulse(11'h010, 1'b0);
    check(16'h8001, 16'hF7BF, 8'h08, 1'b0);
    pulse(11'h200, 1'b1);
    check(16'h0004, 16'hF7BF, 8'h00, 1'b0);
    for (int k = 0; k < 3; k++) begin
      pulse(11'h200, 1'b0);
      @(negedge clk_i);
      {tog, onoff, bias} = {k == 0, k == 1, k != 2};
      @(negedge clk_i);
      {tog, onoff, bias} = 3'b001;
      repeat (3) @(posedge clk_i);
      check(16'h0000, 16'hF7BF, 8'h00, 1'b1);
    end
    @(negedge clk_i) cmd_v = 1'b1;
    @(negedge clk_i) cmd_v = 1'b0;
    pulse('0, 1'b0);
    check(16'h0000, 16'hF7BF, 8'h00, 1'b1);
    @(negedge clk_i) cmd_v = 1'b1;
    @(negedge clk_i) cmd_v = 1'b0;
    cmd_d = 1'b1;
    @(negedge clk_i) cmd_d = 1'b0;
    pulse('0, 1'b0);
    check(16'h0080, 16'hF7BF, 8'h00, 1'b0);
    @(negedge clk_i) {pg_out, perm, chon} = 3'b000;
    pulse('0, 1'b1);
    check(16'h0840, 16'h0840, 8'h00, 1'b1);
    @(negedge clk_i) {pg_out, perm, chon} = 3'b111;
    pulse('0, 1'b1);
    check(16'h0000, 16'hFFFF, 8'h00, 1'b1);
    for (int n = 0; n < 20; n++) begin
      lfsr = nxt(lfsr);
      {we, m, ve} = {16'h0000, 16'hF7BF, 8'h00};
      for (int i = 0; i < 11; i++) begin
        if (lfsr[i] && i != 4) begin
          we |= WEXP[i];
          ve |= VEXP[i];
          m &= msk(i);
        end
      end
      pulse(lfsr[10:0] & 11'h7EF, 1'b0);
      check(we, m, ve, ~|(lfsr[10:0] & 11'h7EF));
      pulse('0, 1'b1);
    end
    end_sim();
  end
endmodule : testbench
